// ---- core/suspend_gate_defines.svh ----
// Constants of the suspend command gate: opcodes, status bit positions, timing counts.
// Assumes a 100 MHz system clock; times are in ns.
`ifndef SUSPEND_GATE_DEFINES_SVH
`define SUSPEND_GATE_DEFINES_SVH

`define OPC_SUSPEND 8'h75
`define OPC_RESUME 8'h7A
`define OPC_LOCK_READ 8'h2D
`define OPC_RD_STATUS1 8'h05
`define OPC_RD_STATUS2 8'h35
`define OPC_RD_STATUS3 8'h15
`define OPC_RESET_ENABLE 8'h66
`define OPC_RESET_DEVICE 8'h99

// Opcode groups, used as case item lists
`define OPC_SINGLE_READS 8'h03, 8'h13, 8'h0B, 8'h0D, 8'h0C
`define OPC_DUAL_READS 8'h3B, 8'h3C, 8'hBB, 8'hBD, 8'hBC
`define OPC_QUAD_READS 8'h6B, 8'h6C, 8'hEB, 8'hED, 8'hEC, 8'hEE, 8'hE7
`define OPC_SETUP_ID_READS 8'h77, 8'hC0, 8'h90, 8'h92, 8'h94, 8'h9F, 8'h4B, 8'hAB, 8'h48, 8'h5A
`define OPC_PROTECT_READS 8'hA7, 8'hE2, 8'h3D, 8'hAA, 8'h27
`define OPC_PAGE_PROGRAMS 8'h02, 8'h12, 8'h32, 8'h34
`define OPC_AREA_ERASES 8'h20, 8'h21, 8'h52, 8'h5C, 8'hD8, 8'hDC

// Status word layout
`define SR_PROG_PAUSED_BIT 15
`define SR_ERASE_PAUSED_BIT 10
`define SR_WIP_BIT 0

// Lock register
`define LOCK_WIDTH 16
`define LOCK_MODE_MSB 2
`define LOCK_MODE_LSB 1

// Timing
`define MCLK_PERIOD_NS 10
`define PROG_PAUSE_LAT_NS 20000
`define ERASE_PAUSE_LAT_NS 20000
`define RESUME_WIP_MAX_NS 200
`define PROG_PAUSE_CYCLES ((`PROG_PAUSE_LAT_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`define ERASE_PAUSE_CYCLES ((`ERASE_PAUSE_LAT_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`define RESUME_WIP_CYCLES (`RESUME_WIP_MAX_NS / `MCLK_PERIOD_NS)

`endif

// ---- core/suspend_gate_pkg.sv ----
// Types of the suspend command gate.
// Assumes nothing beyond a SystemVerilog compiler.
package suspend_gate_pkg;

  typedef enum logic [2:0] {
    CLS_ANYTIME,
    CLS_COMMON,
    CLS_PROGRAM,
    CLS_ERASE,
    CLS_OTHER
  } op_class_t;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_PROG_WAIT,
    ST_ERASE_WAIT,
    ST_PROG_HELD,
    ST_ERASE_HELD
  } pause_state_t;

  typedef enum logic [1:0] {
    FR_IDLE,
    FR_OPCODE,
    FR_DATA
  } frame_state_t;

endpackage

// ---- core/pin_sync.sv ----
// Two-flop synchroniser for a group of pin inputs.
// Assumes the pins are asynchronous to clk; ce freezes both stages.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clocking
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Pins in, synchronised out
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_reg <= RST_VAL;
      dout <= RST_VAL;
    end
    else if (ce)
    begin
      meta_reg <= din;
      dout <= meta_reg;
    end
  end

endmodule
`default_nettype wire

// ---- core/opcode_sorter.sv ----
// Sorts an opcode into its acceptance class during a suspend.
// Purely combinational; the caller applies the class to its suspend state.
`timescale 1ns/1ps
`default_nettype none
`include "suspend_gate_defines.svh"
module opcode_sorter (
  // Opcode in
  input wire logic [7:0] opcode,
  // Class out
  output var suspend_gate_pkg::op_class_t op_class
);
  import suspend_gate_pkg::*;

  function automatic op_class_t classify(input logic [7:0] op);
    op_class_t c;
    c = CLS_OTHER;
    case (op)
      `OPC_RD_STATUS1, `OPC_RD_STATUS2, `OPC_RD_STATUS3,
      `OPC_RESET_ENABLE, `OPC_RESET_DEVICE:
        c = CLS_ANYTIME;
      `OPC_SINGLE_READS, `OPC_DUAL_READS, `OPC_QUAD_READS,
      `OPC_SETUP_ID_READS, `OPC_PROTECT_READS,
      `OPC_RESUME, `OPC_LOCK_READ:
        c = CLS_COMMON;
      `OPC_PAGE_PROGRAMS:
        c = CLS_PROGRAM;
      `OPC_AREA_ERASES:
        c = CLS_ERASE;
      default:
        c = CLS_OTHER;
    endcase
    return c;
  endfunction

  always_comb
  begin
    op_class = classify(opcode);
  end

endmodule
`default_nettype wire

// ---- core/flash_suspend_cmd_gate.sv ----
// Command gate of a serial flash while a program or erase is suspended.
// Assumes the pins come from an outside controller and the array engine runs on MCLK.
//
// What this block does
// (R1) Suspend opcode pauses a running page program or area erase.
// (R2) Program-paused flag is status bit 15, erase-paused flag is bit 10.
// (R3) General suspend commands wait out the pause latency after the suspend.
// (R4) Single-line reads are accepted in both suspend states.
// (R5) Dual-line reads are accepted in both suspend states.
// (R6) Quad-line reads and quad word read are accepted in both suspend states.
// (R7) Wrap, read-parameter, identification and table reads accepted in both states.
// (R8) Page programs accepted only while an erase is suspended.
// (R9) Area erases accepted only while a program is suspended.
// (R10) Resume and protection reads are accepted in both suspend states.
// (R11) Status reads and reset pair accepted right after suspend, no latency.
// (R12) Resume taken only with suspend flag one and write-in-progress zero.
// (R13) Otherwise resume is dropped without any effect.
// (R14) Resume clears suspend flag at once, raises write-in-progress within 200 ns.
// (R15) A 16-bit lock register holds the protection mode in bits 2 and 1.
// (R16) Host shifts the lock read opcode in on rising serial clock edges.
// (R17) Lock register goes out on falling edges, most significant bit first.
// (R18) Opcodes outside the suspend state's set are ignored.
`timescale 1ns/1ps
`default_nettype none
`include "suspend_gate_defines.svh"
module flash_suspend_cmd_gate #(
  parameter logic [15:0] PROG_PAUSE_CYC = 16'(`PROG_PAUSE_CYCLES),
  parameter logic [15:0] ERASE_PAUSE_CYC = 16'(`ERASE_PAUSE_CYCLES)
) (
  // Clock, reset, enable
  input wire logic MCLK,
  input wire logic RST,
  input wire logic CE,
  // Serial pins
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic SI,
  output logic SO,
  output logic SO_OE,
  // Array engine
  input wire logic ENGINE_BUSY,
  input wire logic ENGINE_ERASE,
  input wire logic [15:0] LOCK_OTP,
  output logic ENGINE_PAUSE,
  output logic ENGINE_RESUME,
  // Command hand-off
  output logic CMD_VALID,
  output logic CMD_IGNORED,
  output logic [7:0] CMD_OPCODE,
  // Status
  output logic WRITE_IN_PROGRESS,
  output logic SUSPEND_FLAG,
  output logic PROGRAM_PAUSED,
  output logic ERASE_PAUSED,
  output logic [1:0] PROTECT_MODE
);
  import suspend_gate_pkg::*;

  localparam int RESUME_WIP_CYC = `RESUME_WIP_CYCLES;

  // Pin sampling
  logic [2:0] pins_s;
  logic sclk_s;
  logic cs_n_s;
  logic si_s;

  pin_sync #(.W(3), .RST_VAL(3'b010)) u_pin_sync (
    .clk(MCLK),
    .rst(RST),
    .ce(CE),
    .din({SCLK, CS_N, SI}),
    .dout(pins_s)
  );

  assign sclk_s = pins_s[2];
  assign cs_n_s = pins_s[1];
  assign si_s = pins_s[0];

  // Frame state
  frame_state_t frame_reg, frame_next;
  logic sclk_d_reg, sclk_d_next;
  logic [2:0] bit_reg, bit_next;
  logic [6:0] shin_reg, shin_next;
  logic [15:0] out_reg, out_next;
  logic drive_reg, drive_next;
  logic so_next;
  logic so_oe_next;

  // Suspend state
  pause_state_t pause_reg, pause_next;
  logic [15:0] cnt_reg, cnt_next;
  logic wait_reg, wait_next;
  logic wip_next;
  logic susp_next;
  logic prog_next;
  logic erase_next;
  logic pause_pulse_next;
  logic resume_pulse_next;
  logic valid_next;
  logic ignored_next;
  logic [7:0] code_next;
  logic [15:0] lock_reg;
  logic [1:0] mode_next;

  // Decode of the opcode just completed
  logic rise;
  logic fall;
  logic op_done;
  logic [7:0] opcode;
  op_class_t op_class;
  logic allow;
  logic resume_ok;
  logic out_load;
  logic [15:0] out_val;
  logic [15:0] status_word;

  assign rise = sclk_s & ~sclk_d_reg;
  assign fall = ~sclk_s & sclk_d_reg;
  assign opcode = {shin_reg, si_s};
  assign op_done = ~cs_n_s & rise & (frame_reg != FR_DATA) & (bit_reg == 3'd7); // R16

  opcode_sorter u_opcode_sorter (
    .opcode(opcode),
    .op_class(op_class)
  );

  // Acceptance and suspend sequencing
  always_comb
  begin
    pause_next = pause_reg;
    cnt_next = cnt_reg;
    pause_pulse_next = 1'b0;
    resume_pulse_next = 1'b0;
    valid_next = 1'b0;
    ignored_next = 1'b0;
    code_next = CMD_OPCODE;
    resume_ok = SUSPEND_FLAG & ~WRITE_IN_PROGRESS; // R12
    case (pause_reg)
      ST_RUN:
        allow = 1'b1;
      ST_PROG_WAIT, ST_ERASE_WAIT:
        allow = (op_class == CLS_ANYTIME); // R3 R11
      ST_PROG_HELD:
        allow = (op_class == CLS_ANYTIME) || (op_class == CLS_COMMON) ||
          (op_class == CLS_ERASE); // R4 R5 R6 R7 R9 R10
      default:
        allow = (op_class == CLS_ANYTIME) || (op_class == CLS_COMMON) ||
          (op_class == CLS_PROGRAM); // R4 R5 R6 R7 R8 R10
    endcase
    if (pause_reg == ST_PROG_WAIT || pause_reg == ST_ERASE_WAIT)
    begin
      if (cnt_reg == 16'h0000)
      begin
        pause_next = (pause_reg == ST_PROG_WAIT) ? ST_PROG_HELD : ST_ERASE_HELD; // R3
      end
      else
      begin
        cnt_next = cnt_reg - 16'h0001;
      end
    end
    if (op_done)
    begin
      code_next = opcode;
      if (opcode == `OPC_SUSPEND && pause_reg == ST_RUN && WRITE_IN_PROGRESS)
      begin
        pause_pulse_next = 1'b1; // R1
        pause_next = ENGINE_ERASE ? ST_ERASE_WAIT : ST_PROG_WAIT;
        cnt_next = (ENGINE_ERASE ? ERASE_PAUSE_CYC : PROG_PAUSE_CYC) - 16'h0001;
      end
      else if (opcode == `OPC_SUSPEND)
      begin
        ignored_next = 1'b1;
      end
      else if (opcode == `OPC_RESUME)
      begin
        if (allow && resume_ok)
        begin
          resume_pulse_next = 1'b1; // R14
          pause_next = ST_RUN;
        end
        else
        begin
          ignored_next = 1'b1; // R13
        end
      end
      else if (allow)
      begin
        valid_next = 1'b1;
      end
      else
      begin
        ignored_next = 1'b1; // R18
      end
    end
    prog_next = (pause_next == ST_PROG_HELD); // R2
    erase_next = (pause_next == ST_ERASE_HELD); // R2
    susp_next = prog_next | erase_next;
    wait_next = resume_pulse_next | (wait_reg & ~ENGINE_BUSY);
    wip_next = ENGINE_BUSY | wait_next; // R14
    mode_next = lock_reg[`LOCK_MODE_MSB:`LOCK_MODE_LSB]; // R15
  end

  // Read data chosen when the opcode completes
  always_comb
  begin
    status_word = 16'h0000;
    status_word[`SR_PROG_PAUSED_BIT] = PROGRAM_PAUSED; // R2
    status_word[`SR_ERASE_PAUSED_BIT] = ERASE_PAUSED; // R2
    status_word[`SR_WIP_BIT] = WRITE_IN_PROGRESS;
    out_load = allow;
    out_val = 16'h0000;
    if (opcode == `OPC_LOCK_READ)
    begin
      out_val = lock_reg; // R17
    end
    else if (opcode == `OPC_RD_STATUS1)
    begin
      out_val = {status_word[7:0], status_word[7:0]};
    end
    else if (opcode == `OPC_RD_STATUS2)
    begin
      out_val = {status_word[15:8], status_word[15:8]};
    end
    else if (opcode == `OPC_RD_STATUS3)
    begin
      out_val = 16'h0000;
    end
    else
    begin
      out_load = 1'b0;
    end
  end

  // Serial framing and shift-out
  always_comb
  begin
    frame_next = frame_reg;
    sclk_d_next = sclk_s;
    bit_next = bit_reg;
    shin_next = shin_reg;
    out_next = out_reg;
    drive_next = drive_reg;
    so_next = SO;
    so_oe_next = SO_OE;
    if (cs_n_s)
    begin
      frame_next = FR_IDLE;
      bit_next = 3'd0;
      drive_next = 1'b0;
      so_oe_next = 1'b0;
    end
    else if (frame_reg != FR_DATA)
    begin
      frame_next = FR_OPCODE;
      if (rise)
      begin
        shin_next = {shin_reg[5:0], si_s}; // R16
        bit_next = bit_reg + 3'd1;
        if (bit_reg == 3'd7)
        begin
          frame_next = FR_DATA;
          drive_next = out_load;
          out_next = out_val;
        end
      end
    end
    else if (fall && drive_reg)
    begin
      so_next = out_reg[15]; // R17
      so_oe_next = 1'b1;
      out_next = {out_reg[14:0], out_reg[15]};
    end
  end

  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      frame_reg <= FR_IDLE;
      sclk_d_reg <= 1'b0;
      bit_reg <= 3'd0;
      shin_reg <= 7'h00;
      out_reg <= 16'h0000;
      drive_reg <= 1'b0;
      SO <= 1'b0;
      SO_OE <= 1'b0;
    end
    else if (CE)
    begin
      frame_reg <= frame_next;
      sclk_d_reg <= sclk_d_next;
      bit_reg <= bit_next;
      shin_reg <= shin_next;
      out_reg <= out_next;
      drive_reg <= drive_next;
      SO <= so_next;
      SO_OE <= so_oe_next;
    end
  end

  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      pause_reg <= ST_RUN;
      cnt_reg <= 16'h0000;
      wait_reg <= 1'b0;
      lock_reg <= 16'h0000;
      WRITE_IN_PROGRESS <= 1'b0;
      SUSPEND_FLAG <= 1'b0;
      PROGRAM_PAUSED <= 1'b0;
      ERASE_PAUSED <= 1'b0;
      ENGINE_PAUSE <= 1'b0;
      ENGINE_RESUME <= 1'b0;
      CMD_VALID <= 1'b0;
      CMD_IGNORED <= 1'b0;
      CMD_OPCODE <= 8'h00;
      PROTECT_MODE <= 2'b00;
    end
    else if (CE)
    begin
      pause_reg <= pause_next;
      cnt_reg <= cnt_next;
      wait_reg <= wait_next;
      lock_reg <= LOCK_OTP;
      WRITE_IN_PROGRESS <= wip_next;
      SUSPEND_FLAG <= susp_next;
      PROGRAM_PAUSED <= prog_next;
      ERASE_PAUSED <= erase_next;
      ENGINE_PAUSE <= pause_pulse_next;
      ENGINE_RESUME <= resume_pulse_next;
      CMD_VALID <= valid_next;
      CMD_IGNORED <= ignored_next;
      CMD_OPCODE <= code_next;
      PROTECT_MODE <= mode_next;
    end
  end

  // Checks
  a_flags_track_state: assert property (@(posedge MCLK) disable iff (RST) // R2
    (PROGRAM_PAUSED == (pause_reg == ST_PROG_HELD)) &&
    (ERASE_PAUSED == (pause_reg == ST_ERASE_HELD)) &&
    (SUSPEND_FLAG == (PROGRAM_PAUSED || ERASE_PAUSED)))
    else $error("suspend flags disagree with suspend state");

  a_wait_blocks_common: assert property (@(posedge MCLK) disable iff (RST || !CE) // R3
    (op_done && (pause_reg == ST_PROG_WAIT || pause_reg == ST_ERASE_WAIT) &&
    op_class != CLS_ANYTIME) |=> (!CMD_VALID && !ENGINE_RESUME))
    else $error("command taken before pause latency elapsed");

  a_anytime_passes: assert property (@(posedge MCLK) disable iff (RST || !CE) // R11
    (op_done && pause_reg != ST_RUN && op_class == CLS_ANYTIME) |=> CMD_VALID)
    else $error("status or reset opcode not taken during suspend");

  a_common_passes: assert property (@(posedge MCLK) disable iff (RST || !CE) // R4
    (op_done && (pause_reg == ST_PROG_HELD || pause_reg == ST_ERASE_HELD) &&
    op_class == CLS_COMMON && opcode != `OPC_RESUME) |=> (CMD_VALID && !CMD_IGNORED))
    else $error("read opcode not taken while suspended");

  a_prog_held_rejects: assert property (@(posedge MCLK) disable iff (RST || !CE) // R8
    (op_done && pause_reg == ST_PROG_HELD && op_class == CLS_PROGRAM) |=>
    (CMD_IGNORED && !CMD_VALID))
    else $error("page program taken while program suspended");

  a_erase_held_rejects: assert property (@(posedge MCLK) disable iff (RST || !CE) // R9
    (op_done && pause_reg == ST_ERASE_HELD && op_class == CLS_ERASE) |=>
    (CMD_IGNORED && !CMD_VALID))
    else $error("erase taken while erase suspended");

  a_resume_dropped: assert property (@(posedge MCLK) disable iff (RST || !CE) // R13
    (op_done && opcode == `OPC_RESUME && (!SUSPEND_FLAG || WRITE_IN_PROGRESS)) |=>
    (!ENGINE_RESUME && CMD_IGNORED && (SUSPEND_FLAG || !$past(SUSPEND_FLAG))))
    else $error("resume acted without suspend or while busy");

  a_resume_effect: assert property (@(posedge MCLK) disable iff (RST || !CE) // R14
    (op_done && opcode == `OPC_RESUME && SUSPEND_FLAG && !WRITE_IN_PROGRESS) |=>
    (ENGINE_RESUME && !SUSPEND_FLAG && WRITE_IN_PROGRESS))
    else $error("resume did not clear suspend and raise busy");

  a_resume_wip_time: assert property (@(posedge MCLK) disable iff (RST) // R14
    $rose(ENGINE_RESUME) |-> ##[0:RESUME_WIP_CYC] WRITE_IN_PROGRESS)
    else $error("write in progress late after resume");

  a_lock_msb_first: assert property (@(posedge MCLK) disable iff (RST || !CE) // R17
    (frame_reg == FR_DATA && !cs_n_s && fall && drive_reg) |=>
    (SO == $past(out_reg[15]) && SO_OE))
    else $error("shift-out bit order wrong");

endmodule
`default_nettype wire

// ---- test/host_spi_model.sv ----
// Host serial controller model: drives select, serial clock and data in.
// Assumes the device samples on rising and shifts out on falling clock edges.
`timescale 1ns/1ps
`default_nettype none
module host_spi_model (
  // Serial pins
  output logic SCLK,
  output logic CS_N,
  output logic SI,
  input wire logic SO
);
  initial
  begin
    SCLK = 1'b0;
    CS_N = 1'b1;
    SI = 1'b0;
  end

  // One frame: opcode MSB first, then nrd bits read back
  task automatic xfer(input [7:0] op, input int nrd, output [15:0] rd);
    rd = '0;
    CS_N = 1'b0;
    #120;
    for (int i = 7; i >= 0; i--)
    begin
      SI = op[i];
      #40 SCLK = 1'b1;
      #40 SCLK = 1'b0;
    end
    for (int j = 0; j < nrd; j++)
    begin
      SI = ~SI;
      #40 SCLK = 1'b1;
      #40 rd = {rd[14:0], SO};
      SCLK = 1'b0;
    end
    #40 CS_N = 1'b1;
    // Released line must not keep its last value
    SI = ~SI;
    #120;
  endtask
endmodule
`default_nettype wire

// ---- test/tb_top.sv ----
// Testbench of the suspend command gate.
// Assumes the host model drives the serial pins; the bench plays the array engine.
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, exp, got) \
  begin \
    checks++; \
    if ((got) !== (exp)) \
    begin \
      num_errors++; \
      $display("MISMATCH %s expected %h seen %h", nm, exp, got); \
    end \
  end
module tb_top;
  import suspend_gate_pkg::*;
  localparam logic [15:0] PAUSE_CYC = 16'h0190;
  localparam logic [15:0] LOCK_VAL = 16'hA53C;
  localparam int LIMIT = 30000;
  logic MCLK, RST, CE, ENGINE_BUSY, ENGINE_ERASE;
  logic [15:0] LOCK_OTP;
  logic SCLK, CS_N, SI, SO, SO_OE, ENGINE_PAUSE, ENGINE_RESUME, CMD_VALID, CMD_IGNORED;
  logic WRITE_IN_PROGRESS, SUSPEND_FLAG, PROGRAM_PAUSED, ERASE_PAUSED;
  logic [7:0] CMD_OPCODE;
  logic [1:0] PROTECT_MODE;
  logic flag_at_resume;
  int num_errors = 0;
  int checks = 0;
  int cyc = 0;
  int n_valid = 0;
  int n_ign = 0;
  int n_pause = 0;
  int n_resume = 0;
  int pause_at = 0;
  int rise_at = 0;
  // {accepted in program suspend, accepted in erase suspend, opcode}
  logic [9:0] rows [0:47] = '{
    10'h303, 10'h313, 10'h30B, 10'h30D, 10'h30C, 10'h33B, 10'h33C, 10'h3BB,
    10'h3BD, 10'h3BC, 10'h36B, 10'h36C, 10'h3EB, 10'h3ED, 10'h3EC, 10'h3EE,
    10'h3E7, 10'h377, 10'h3C0, 10'h390, 10'h392, 10'h394, 10'h39F, 10'h34B,
    10'h3AB, 10'h348, 10'h35A, 10'h32D, 10'h3A7, 10'h3E2, 10'h33D, 10'h3AA,
    10'h327, 10'h305, 10'h335, 10'h315, 10'h102, 10'h112, 10'h132, 10'h134,
    10'h220, 10'h221, 10'h252, 10'h25C, 10'h2D8, 10'h2DC, 10'h060, 10'h075};

  flash_suspend_cmd_gate #(
    .PROG_PAUSE_CYC(PAUSE_CYC),
    .ERASE_PAUSE_CYC(PAUSE_CYC)
  ) flash_suspend_cmd_gate_inst (
    .MCLK(MCLK), .RST(RST), .CE(CE),
    .SCLK(SCLK), .CS_N(CS_N), .SI(SI), .SO(SO), .SO_OE(SO_OE),
    .ENGINE_BUSY(ENGINE_BUSY), .ENGINE_ERASE(ENGINE_ERASE), .LOCK_OTP(LOCK_OTP),
    .ENGINE_PAUSE(ENGINE_PAUSE), .ENGINE_RESUME(ENGINE_RESUME),
    .CMD_VALID(CMD_VALID), .CMD_IGNORED(CMD_IGNORED), .CMD_OPCODE(CMD_OPCODE),
    .WRITE_IN_PROGRESS(WRITE_IN_PROGRESS), .SUSPEND_FLAG(SUSPEND_FLAG), .PROGRAM_PAUSED(PROGRAM_PAUSED),
    .ERASE_PAUSED(ERASE_PAUSED), .PROTECT_MODE(PROTECT_MODE)
  );

  host_spi_model host_spi_model_inst (
    .SCLK(SCLK),
    .CS_N(CS_N),
    .SI(SI),
    .SO(SO)
  );

  initial
  begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end

  // Pulse counters, event times and the hang limit
  always @(posedge MCLK)
  begin
    cyc <= cyc + 1;
    if (CMD_VALID === 1'b1)
      n_valid <= n_valid + 1;
    if (CMD_IGNORED === 1'b1)
      n_ign <= n_ign + 1;
    if (ENGINE_PAUSE === 1'b1)
      pause_at <= cyc;
    if (ENGINE_PAUSE === 1'b1)
      n_pause <= n_pause + 1;
    if (ENGINE_RESUME === 1'b1)
      n_resume <= n_resume + 1;
    if (ENGINE_RESUME === 1'b1)
      flag_at_resume <= SUSPEND_FLAG;
    if ($rose(SUSPEND_FLAG))
      rise_at <= cyc;
    if (cyc == LIMIT)
    begin
      num_errors++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Link clock phase unrelated to MCLK
  task automatic frame(input [7:0] op, input int nrd, output [15:0] rd);
    @(posedge MCLK);
    #3.7;
    host_spi_model_inst.xfer(op, nrd, rd);
    @(posedge MCLK);
    #1;
  endtask

  task automatic cmd(input [7:0] op, input ok);
    int v0;
    int i0;
    logic [15:0] rd;
    v0 = n_valid;
    i0 = n_ign;
    frame(op, 0, rd);
    `CHECK("verdict", {ok, !ok}, {1'(n_valid - v0), 1'(n_ign - i0)})
    `CHECK("opcode", op, CMD_OPCODE)
  endtask

  task automatic set_busy(input b);
    @(posedge MCLK);
    #1;
    ENGINE_BUSY = b;
    repeat (3) @(posedge MCLK);
    #1;
  endtask

  task automatic pause_cycle(input erase);
    logic [15:0] rd;
    int p0;
    ENGINE_ERASE = erase;
    set_busy(1'b1);
    p0 = n_pause;
    frame(8'h75, 0, rd);
    `CHECK("pause pulse", 1, n_pause - p0)
    ENGINE_BUSY = 1'b0;
    cmd(8'h03, 1'b0);
    cmd(8'h66, 1'b1);
    for (int k = 0; k < 1000 && SUSPEND_FLAG !== 1'b1; k++)
      @(posedge MCLK);
    @(posedge MCLK);
    #1;
    `CHECK("latency", PAUSE_CYC, 16'(rise_at - pause_at))
    `CHECK("flags", {~erase, erase, 1'b1}, {PROGRAM_PAUSED, ERASE_PAUSED, SUSPEND_FLAG})
    frame(8'h35, 16, rd);
    `CHECK("status high", erase ? 16'h0404 : 16'h8080, rd)
    for (int r = 0; r < 48; r++)
    begin
      cmd(rows[r][7:0], erase ? rows[r][8] : rows[r][9]);
      `CHECK("still paused", 1'b1, SUSPEND_FLAG)
    end
    frame(8'h2D, 16, rd);
    `CHECK("lock data", LOCK_VAL, rd)
    `CHECK("lock mode", LOCK_VAL[2:1], PROTECT_MODE)
    `CHECK("out enable idle", 1'b0, SO_OE)
    // Nested operation keeps write in progress, so resume is dropped
    set_busy(1'b1);
    p0 = n_resume;
    frame(8'h7A, 0, rd);
    `CHECK("resume dropped", {p0, 1'b1}, {n_resume, SUSPEND_FLAG})
    set_busy(1'b0);
    frame(8'h7A, 0, rd);
    `CHECK("resume taken", p0 + 1, n_resume)
    `CHECK("flag at resume", 1'b0, flag_at_resume)
    `CHECK("after resume", 2'b01, {SUSPEND_FLAG, WRITE_IN_PROGRESS})
    set_busy(1'b1);
    set_busy(1'b0);
    `CHECK("done", 1'b0, WRITE_IN_PROGRESS)
  endtask

  initial
  begin
    logic [15:0] rd;
    int p0;
    RST = 1'b1;
    CE = 1'b1;
    ENGINE_BUSY = 1'b0;
    ENGINE_ERASE = 1'b0;
    LOCK_OTP = LOCK_VAL;
    repeat (10) @(posedge MCLK);
    #1;
    RST = 1'b0;
    `CHECK("reset outputs", 4'h0, {SUSPEND_FLAG, WRITE_IN_PROGRESS, SO_OE, ENGINE_PAUSE})
    repeat (5) @(posedge MCLK);
    p0 = n_resume;
    frame(8'h7A, 0, rd);
    `CHECK("resume in run", p0, n_resume)
    pause_cycle(1'b0);
    pause_cycle(1'b1);
    // Clock enable low: a whole frame passes unseen
    p0 = n_valid + n_ign;
    CE = 1'b0;
    frame(8'h05, 0, rd);
    CE = 1'b1;
    `CHECK("frozen frame", {p0, 8'h7A}, {n_valid + n_ign, CMD_OPCODE})
    frame(8'h05, 0, rd);
    `CHECK("after freeze", {p0 + 1, 8'h05}, {n_valid + n_ign, CMD_OPCODE})
    // Reset in the middle of a suspend latency
    set_busy(1'b1);
    p0 = n_pause;
    frame(8'h75, 0, rd);
    `CHECK("mid pause", p0 + 1, n_pause)
    RST = 1'b1;
    @(posedge MCLK);
    #1;
    RST = 1'b0;
    `CHECK("mid reset", 10'h000, {SUSPEND_FLAG, WRITE_IN_PROGRESS, CMD_OPCODE})
    set_busy(1'b0);
    repeat (450) @(posedge MCLK);
    #1;
    `CHECK("no late suspend", 2'b00, {SUSPEND_FLAG, ENGINE_PAUSE})
    final_report();
  end
endmodule
`default_nettype wire
